//--- hdl/wlb_pkg.sv
package wlb_pkg;

	// ------------------------------------------------------------
	// i/o port addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_SUP_CTRL  = 16'h0062;
	localparam logic [15:0] ADDR_SUP_KICK  = 16'h0066;
	localparam logic [15:0] ADDR_BATT      = 16'h404D;
	localparam logic [15:0] ADDR_LAMP_LO   = 16'h404E;
	localparam logic [15:0] ADDR_LAMP_HI   = 16'h404F;

	// ------------------------------------------------------------
	// watchdog control fields
	// ------------------------------------------------------------
	localparam int BIT_SUP_EN    = 0;
	localparam int BIT_SUP_MACRO = 1;
	localparam int BIT_SUP_SEL   = 2;
	localparam int BIT_SCALE_LO  = 3;
	localparam int BIT_SCALE_HI  = 5;
	localparam int BIT_SUP_RED   = 6;
	localparam int BIT_SUP_ALARM = 7;
	localparam logic [6:0] SUP_CTRL_RST = 7'h04;

	// ------------------------------------------------------------
	// lamp register fields
	// ------------------------------------------------------------
	localparam int BIT_LAMP1_SEL = 15;
	localparam int BIT_LAMP1_COL = 7;
	localparam int BIT_LAMP2_SEL = 14;
	localparam int BIT_LAMP2_COL = 6;
	localparam int BIT_LAMP3_SEL = 13;
	localparam int BIT_LAMP3_COL = 5;
	localparam logic [15:0] LAMP_RST = 16'hFFFF;

	// ------------------------------------------------------------
	// battery codes in bits 7:6
	// ------------------------------------------------------------
	localparam logic [1:0] BATT_OK    = 2'h0;
	localparam logic [1:0] BATT_LOW   = 2'h1;
	localparam logic [1:0] BATT_EMPTY = 2'h3;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [7:0] RD_KICK     = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ = 125000000;
	localparam int MS_PER_S   = 1000;
	localparam int CYC_PER_MS = SYS_CLK_HZ / MS_PER_S;

	// timeouts in ms, standard then macro, indexed by scaler code
	// standard: 94 to 960 ms
	localparam logic [15:0] TO_STD_MS [8] = '{
		16'h005E, 16'h00D2, 16'h0154, 16'h01CC,
		16'h024E, 16'h02C6, 16'h0348, 16'h03C0};
	// macro: 2 s to 64 s
	localparam logic [15:0] TO_MACRO_MS [8] = '{
		16'h07D0, 16'h0FA0, 16'h1770, 16'h1F40,
		16'h3E80, 16'h7D00, 16'hBB80, 16'hFA00};

endpackage

//--- hdl/wlb_regs.sv
`timescale 1ns/1ps

// What this block does
// - control bit 0 enables the watchdog
// - bit 1 base, bits 5:3 pick timeout
// - scaler resets to shortest timeout code
// - control bit 6 drives red lamp
// - bit 7 alarm flag, write 1 clears
// - any read of 066h retriggers watchdog
// - bit 2 selects 066h function, keep 1
// - bits 15/7 drive lamp one colours
// - bits 14/6 drive lamp two colours
// - bits 13/5 drive lamp three colours
// - battery code 00 when capacity sufficient
// - battery code 01 when nearly exhausted
// - battery code 11 when battery empty
module wlb_regs #(
	parameter int CYC_PER_MS = wlb_pkg::CYC_PER_MS
)(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// i/o port access, byte wide
	input  wire logic [15:0] i_io_addr,
	input  wire logic        i_io_rd,
	input  wire logic        i_io_wr,
	input  wire logic [7:0]  i_io_wdata,
	output logic [7:0]       o_io_rdata,
	output logic             o_io_rvalid,
	// battery monitor pins
	input  wire logic        i_batt_low,
	input  wire logic        i_batt_empty,
	// indicators
	output logic             o_sup_red_lamp,
	output logic             o_sup_alarm,
	output logic             o_lamp1_green,
	output logic             o_lamp1_yellow,
	output logic             o_lamp2_red,
	output logic             o_lamp2_yellow,
	output logic             o_lamp3_red,
	output logic             o_lamp3_yellow
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic wr_ctrl;
	logic wr_lamp_lo;
	logic wr_lamp_hi;
	logic kick;

	assign wr_ctrl    = i_io_wr && (i_io_addr == wlb_pkg::ADDR_SUP_CTRL);
	assign wr_lamp_lo = i_io_wr && (i_io_addr == wlb_pkg::ADDR_LAMP_LO);
	assign wr_lamp_hi = i_io_wr && (i_io_addr == wlb_pkg::ADDR_LAMP_HI);
	// bit 2 = 0 is reserved; the kick is honoured either way
	assign kick = i_io_rd && (i_io_addr == wlb_pkg::ADDR_SUP_KICK);

	// ------------------------------------------------------------
	// watchdog control
	// ------------------------------------------------------------
	logic [6:0]  ctrl_r;
	logic        alarm_r;
	logic        expire;
	logic [2:0]  scale;
	logic [15:0] limit_ms;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			ctrl_r <= wlb_pkg::SUP_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= i_io_wdata[6:0];
	end

	// expiry wins over a clearing write in the same cycle
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			alarm_r <= 1'b0;
		else if (expire)
			alarm_r <= 1'b1;
		else if (wr_ctrl && i_io_wdata[wlb_pkg::BIT_SUP_ALARM])
			alarm_r <= 1'b0;
	end

	assign scale = ctrl_r[wlb_pkg::BIT_SCALE_HI:wlb_pkg::BIT_SCALE_LO];

	assign limit_ms = ctrl_r[wlb_pkg::BIT_SUP_MACRO]
		? wlb_pkg::TO_MACRO_MS[scale]
		: wlb_pkg::TO_STD_MS[scale];

	wlb_sup_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.i_sys_clk  (i_sys_clk),
		.i_rst      (i_rst),
		.i_enable   (ctrl_r[wlb_pkg::BIT_SUP_EN]),
		.i_kick     (kick),
		.i_limit_ms (limit_ms),
		.o_expire   (expire)
	);

	// ------------------------------------------------------------
	// lamp register
	// ------------------------------------------------------------
	logic [15:0] lamp_r;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			lamp_r <= wlb_pkg::LAMP_RST;
		else if (wr_lamp_lo)
			lamp_r[7:0] <= i_io_wdata;
		else if (wr_lamp_hi)
			lamp_r[15:8] <= i_io_wdata;
	end

	// ------------------------------------------------------------
	// battery status, pins synchronised
	// ------------------------------------------------------------
	logic [1:0] batt_meta_r;
	logic [1:0] batt_sync_r;
	logic [1:0] batt_code;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			batt_meta_r <= 2'h0;
			batt_sync_r <= 2'h0;
		end
		else
		begin
			batt_meta_r <= {i_batt_empty, i_batt_low};
			batt_sync_r <= batt_meta_r;
		end
	end

	// empty takes priority over low
	always_comb
	begin
		if (batt_sync_r[1])
			batt_code = wlb_pkg::BATT_EMPTY;
		else if (batt_sync_r[0])
			batt_code = wlb_pkg::BATT_LOW;
		else
			batt_code = wlb_pkg::BATT_OK;
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [7:0] rd_nxt;

	always_comb
	begin
		unique case (i_io_addr)
			wlb_pkg::ADDR_SUP_CTRL: rd_nxt = {alarm_r, ctrl_r};
			wlb_pkg::ADDR_SUP_KICK: rd_nxt = wlb_pkg::RD_KICK;
			wlb_pkg::ADDR_BATT:     rd_nxt = {batt_code, 6'h00};
			wlb_pkg::ADDR_LAMP_LO:  rd_nxt = lamp_r[7:0];
			wlb_pkg::ADDR_LAMP_HI:  rd_nxt = lamp_r[15:8];
			default:                rd_nxt = wlb_pkg::RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_io_rdata  <= 8'h00;
			o_io_rvalid <= 1'b0;
		end
		else
		begin
			o_io_rvalid <= i_io_rd;
			if (i_io_rd)
				o_io_rdata <= rd_nxt;
		end
	end

	// ------------------------------------------------------------
	// registered indicator outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_sup_red_lamp <= 1'b0;
			o_sup_alarm    <= 1'b0;
			o_lamp1_green  <= 1'b0;
			o_lamp1_yellow <= 1'b0;
			o_lamp2_red    <= 1'b0;
			o_lamp2_yellow <= 1'b0;
			o_lamp3_red    <= 1'b0;
			o_lamp3_yellow <= 1'b0;
		end
		else
		begin
			o_sup_red_lamp <= ctrl_r[wlb_pkg::BIT_SUP_RED];
			o_sup_alarm    <= alarm_r;
			o_lamp1_green  <= !lamp_r[wlb_pkg::BIT_LAMP1_SEL];
			o_lamp1_yellow <= lamp_r[wlb_pkg::BIT_LAMP1_SEL]
				&& !lamp_r[wlb_pkg::BIT_LAMP1_COL];
			o_lamp2_red    <= !lamp_r[wlb_pkg::BIT_LAMP2_SEL];
			o_lamp2_yellow <= lamp_r[wlb_pkg::BIT_LAMP2_SEL]
				&& !lamp_r[wlb_pkg::BIT_LAMP2_COL];
			o_lamp3_red    <= !lamp_r[wlb_pkg::BIT_LAMP3_SEL];
			o_lamp3_yellow <= lamp_r[wlb_pkg::BIT_LAMP3_SEL]
				&& !lamp_r[wlb_pkg::BIT_LAMP3_COL];
		end
	end

endmodule

//--- hdl/wlb_wd_timer.sv
`timescale 1ns/1ps

module wlb_sup_timer #(
	parameter int CYC_PER_MS = wlb_pkg::CYC_PER_MS
)(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// control
	input  wire logic        i_enable,
	input  wire logic        i_kick,
	input  wire logic [15:0] i_limit_ms,
	// event
	output logic             o_expire
);

	// ------------------------------------------------------------
	// millisecond enable
	// ------------------------------------------------------------
	logic [31:0] div_r;
	logic        ms_tick;
	logic [15:0] ms_r;

	assign ms_tick = (div_r == 32'(CYC_PER_MS - 1));

	// kick also clears the divider so each timeout is never short
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			div_r <= 32'h0;
		else if (!i_enable || i_kick || ms_tick)
			div_r <= 32'h0;
		else
			div_r <= div_r + 32'h1;
	end

	// ------------------------------------------------------------
	// timeout count
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			ms_r <= 16'h0;
		else if (!i_enable || i_kick)
			ms_r <= 16'h0;
		else if (ms_tick)
		begin
			if (ms_r + 16'h1 >= i_limit_ms)
				ms_r <= 16'h0;
			else
				ms_r <= ms_r + 16'h1;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_expire <= 1'b0;
		else
			o_expire <= i_enable && !i_kick && ms_tick
				&& (ms_r + 16'h1 >= i_limit_ms);
	end

endmodule

//--- tb/wlb_regs_checker.sv
`timescale 1ns/1ps

module wlb_regs_checker (
	// clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	// i/o port
	input wire logic [15:0] i_io_addr,
	input wire logic        i_io_rd,
	input wire logic        i_io_wr,
	input wire logic [7:0]  i_io_wdata,
	input wire logic [7:0]  o_io_rdata,
	input wire logic        o_io_rvalid,
	// pins
	input wire logic        i_batt_empty,
	input wire logic        o_sup_red_lamp,
	input wire logic        o_sup_alarm,
	input wire logic        o_lamp1_green,
	input wire logic        o_lamp1_yellow,
	input wire logic        o_lamp2_red,
	input wire logic        o_lamp2_yellow,
	input wire logic        o_lamp3_red,
	input wire logic        o_lamp3_yellow
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	logic wr_ctl;
	logic clr;
	assign wr_ctl = i_io_wr && i_io_addr == 16'h0062;
	assign clr = wr_ctl && i_io_wdata[7];

	a_rd_answered: assert property (i_io_rd |=> o_io_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (
		o_io_rvalid |-> $past(i_io_rd))
		else $error("stray read valid");
	a_kick_zero: assert property (i_io_rd && i_io_addr == 16'h0066
		|=> o_io_rdata == 8'h00) else $error("kick read not zero");
	a_red_follows: assert property (wr_ctl ##1 !wr_ctl
		|=> o_sup_red_lamp == $past(i_io_wdata[6], 2))
		else $error("red lamp wrong");
	// the output lags the flag by one cycle, so a clear shows two later
	a_alarm_sticky: assert property (
		o_sup_alarm && !clr && !$past(clr) |=> o_sup_alarm)
		else $error("alarm dropped");
	a_alarm_clear: assert property (clr && !i_io_wdata[0]
		|-> ##2 !o_sup_alarm) else $error("alarm not cleared");
	a_lamp1_excl: assert property (
		!(o_lamp1_green && o_lamp1_yellow))
		else $error("lamp one two colours");
	a_lamp2_excl: assert property (
		!(o_lamp2_red && o_lamp2_yellow))
		else $error("lamp two two colours");
	a_lamp3_excl: assert property (
		!(o_lamp3_red && o_lamp3_yellow))
		else $error("lamp three two colours");
	a_batt_empty: assert property (i_batt_empty[*4] ##0 (i_io_rd
		&& i_io_addr == 16'h404D) |=> o_io_rdata[7:6] == 2'h3)
		else $error("battery empty code wrong");
endmodule

bind wlb_regs wlb_regs_checker u_chk (.i_sys_clk, .i_rst, .i_io_addr,
	.i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata, .o_io_rvalid,
	.i_batt_empty, .o_sup_red_lamp, .o_sup_alarm, .o_lamp1_green,
	.o_lamp1_yellow, .o_lamp2_red, .o_lamp2_yellow, .o_lamp3_red,
	.o_lamp3_yellow);

//--- tb/wlb_regs_tb.sv
`timescale 1ns/1ps

module wlb_regs_tb;
	logic        i_sys_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [15:0] i_io_addr = 16'h0000;
	logic        i_io_rd = 1'b0;
	logic        i_io_wr = 1'b0;
	logic [7:0]  i_io_wdata = 8'h00;
	logic        i_batt_low = 1'b0;
	logic        i_batt_empty = 1'b0;
	logic [7:0]  o_io_rdata;
	logic        o_io_rvalid;
	logic        o_sup_red_lamp;
	logic        o_sup_alarm;
	logic [5:0]  lamps;
	int          err_count = 0;
	int          comparisons = 0;

	// ------------------------------------------------------------
	// short ms keeps tested timeouts between 376 and 8000 cycles
	// ------------------------------------------------------------
	wlb_regs #(.CYC_PER_MS(4)) dut (.i_sys_clk, .i_rst, .i_io_addr,
		.i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata, .o_io_rvalid,
		.i_batt_low, .i_batt_empty, .o_sup_red_lamp, .o_sup_alarm,
		.o_lamp1_green(lamps[5]), .o_lamp1_yellow(lamps[4]),
		.o_lamp2_red(lamps[3]), .o_lamp2_yellow(lamps[2]),
		.o_lamp3_red(lamps[1]), .o_lamp3_yellow(lamps[0]));

	initial forever #4 i_sys_clk = ~i_sys_clk;

	task automatic report_and_stop;
		$display("err_count %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge i_sys_clk);
		i_io_addr <= a;
		i_io_wdata <= v;
		i_io_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_io_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_io_addr <= a;
		i_io_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_io_rd <= 1'b0;
		#1;
		chk("rvalid", {7'h00, o_io_rvalid}, 8'h01);
		chk("rdata", o_io_rdata, e);
	endtask

	task automatic t_reset;
		rd(16'h0062, 8'h04);
		rd(16'h404E, 8'hFF);
		rd(16'h404F, 8'hFF);
		chk("lamps", {2'h0, lamps}, 8'h00);
		chk("red", {7'h00, o_sup_red_lamp}, 8'h00);
	endtask

	task automatic t_lamps;
		wr(16'h404F, 8'h20);
		wr(16'h404E, 8'h00);
		tick(2);
		chk("lamps", {2'h0, lamps}, 8'h29);
		wr(16'h404F, 8'hC0);
		tick(2);
		chk("lamps", {2'h0, lamps}, 8'h16);
	endtask

	task automatic t_batt;
		@(posedge i_sys_clk);
		i_batt_low <= 1'b1;
		tick(4);
		rd(16'h404D, 8'h40);
		@(posedge i_sys_clk);
		i_batt_empty <= 1'b1;
		tick(4);
		rd(16'h404D, 8'hC0);
		@(posedge i_sys_clk);
		i_batt_low <= 1'b0;
		i_batt_empty <= 1'b0;
		tick(4);
		rd(16'h404D, 8'h00);
		rd(16'h1234, 8'h00);
	endtask

	task automatic t_kick;
		wr(16'h0062, 8'h05);
		repeat (3)
		begin
			tick(300);
			rd(16'h0066, 8'h00);
		end
		chk("kept", {7'h00, o_sup_alarm}, 8'h00);
		wr(16'h0062, 8'h04);
		tick(400);
		chk("off", {7'h00, o_sup_alarm}, 8'h00);
	endtask

	// expiry expected n cycles after the enabling write
	task automatic t_to(input logic [7:0] c, input int n);
		wr(16'h0062, c);
		tick(n - 8);
		chk("early", {7'h00, o_sup_alarm}, 8'h00);
		tick(16);
		chk("alarm", {7'h00, o_sup_alarm}, 8'h01);
		chk("red", {7'h00, o_sup_red_lamp}, {7'h00, c[6]});
		rd(16'h0062, {1'b1, c[6:0]});
		wr(16'h0062, 8'h84);
		tick(3);
		chk("clear", {7'h00, o_sup_alarm}, 8'h00);
	endtask

	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_reset;
		t_lamps;
		t_batt;
		t_kick;
		t_to(8'h05, 376);
		t_to(8'h4D, 840);
		t_to(8'h07, 8000);
		report_and_stop;
	end

	initial
	begin
		#400000;
		err_count++;
		report_and_stop;
	end
endmodule
